// *** pkg/mhcp_pkg.sv ***
// =====================================================================
// Constants shared by the host control port
package mhcp_pkg;
    // =================================================================
    // Bus and register addressing
    localparam int BUS_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_LINE_CTRL = 3'h0;
    localparam logic [2:0] ADDR_IFACE_CTRL = 3'h1;
    localparam logic [2:0] ADDR_DETECT = 3'h2;
    localparam logic [2:0] ADDR_TONE_CTRL = 3'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] OE_ALL_OFF = 8'hff;
    localparam int SER_DATA_BIT = 7;

    // =================================================================
    // Field positions
    localparam int LC_TX_ENABLE_BIT = 1;
    localparam int LC_MODE_LSB = 2;
    localparam int LC_MODE_MSB = 5;
    localparam int IC_SOFT_RESET_BIT = 2;
    localparam int IC_CLK_CTRL_BIT = 3;
    localparam int IC_INT_ENABLE_BIT = 5;
    localparam int DET_LONG_LOOP_BIT = 0;
    localparam int DET_CALL_PROG_BIT = 1;
    localparam int DET_ANSWER_BIT = 2;
    localparam int DET_CARRIER_BIT = 3;
    localparam int DET_UNSCR_BIT = 4;
    localparam int DET_RX_DATA_BIT = 5;
    localparam logic [7:0] DET_INT_MASK = 8'h1e;
    localparam int TONE_MODE_BIT = 4;
    localparam int TONE_CODE_MSB = 3;

    // =================================================================
    // Transmit mode codes that use phase-shift modulation
    localparam logic [3:0] MODE_PSK_FIRST = 4'h1;
    localparam logic [3:0] MODE_PSK_LAST = 4'h7;

    // =================================================================
    // Serial command shifter
    localparam logic [3:0] SER_BITS = 4'h8;
    typedef enum logic [2:0] {
        SER_IDLE = 3'b001,
        SER_OUT = 3'b010,
        SER_IN = 3'b100
    } mhcp_ser_state_type;

    // =================================================================
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int UNSCR_MARK_US = 165500;
    localparam int UNSCR_TOL_US = 6500;
    localparam int UNSCR_MARK_CYCLES = UNSCR_MARK_US * CLK_MHZ;
    localparam int UNSCR_CNT_W = 23;

    // =================================================================
    // Positions in the synchroniser vector
    localparam int SYNC_W = 19;
    localparam int SY_AD_LSB = 0;
    localparam int SY_LATCH = 8;
    localparam int SY_CS_N = 9;
    localparam int SY_RD_N = 10;
    localparam int SY_WR_N = 11;
    localparam int SY_SHIFT_CLK = 12;
    localparam int SY_RX_DATA = 13;
    localparam int SY_RAW_DEMOD = 14;
    localparam int SY_CARRIER = 15;
    localparam int SY_ANSWER = 16;
    localparam int SY_CALL_PROG = 17;
    localparam int SY_LONG_LOOP = 18;
    localparam logic [18:0] SYNC_IDLE = 19'h01e00;
endpackage : mhcp_pkg

// *** pkg/mhcp_sync_if.sv ***
`timescale 1ns/1ps
// =====================================================================
// Raw pin levels in, filtered levels out
interface mhcp_sync_if;
    import mhcp_pkg::*;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : mhcp_sync_if

// *** tb/mhcp_host.sv ***
`timescale 1ns/1ps
// =====================================================================
// Control processor model on the multiplexed or serial bus
module mhcp_host (
    // Clock
    input wire logic clk,
    // Bus and strobes
    output logic [7:0] ad,
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic sclk,
    // Resolved bus level
    input wire logic [7:0] bus
);
    initial begin
        {ad, ale, cs_n, rd_n, wr_n, sclk} = 13'h000f;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w

    // Parallel cycle; a released bus shows the inverse of the last value
    task automatic par(input logic wr, input logic sel, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        ale = 1'h1;
        cs_n = !sel;
        ad = {5'h00, a};
        w(8);
        ale = 1'h0;
        w(2);
        cs_n = 1'h1;
        ad = ~ad;
        w(6);
        if (wr) begin
            ad = d;
            wr_n = 1'h0;
            w(8);
            wr_n = 1'h1;
            w(8);
        end else begin
            rd_n = 1'h0;
            w(10);
            q = bus;
            rd_n = 1'h1;
            w(8);
        end
        ad = ~ad;
        w(1);
    endtask : par

    // Serial command cycle, n shift-clock periods
    task automatic ser(input logic wr, input logic [2:0] a, input logic [8:0] d,
                       input int n, output logic [7:0] q);
        ale = 1'h1;
        cs_n = 1'h0;
        ad = {5'h00, a};
        w(6);
        if (!wr) begin
            rd_n = 1'h0;
            w(8);
        end
        for (int i = 0; i < n; i++) begin
            if (wr) begin
                ad[7] = d[i];
            end
            w(6);
            if (!wr) begin
                q[i] = bus[7];
            end
            sclk = 1'h0;
            w(6);
            sclk = 1'h1;
        end
        if (wr) begin
            wr_n = 1'h0;
            w(6);
        end
        wr_n = 1'h1;
        rd_n = 1'h1;
        w(8);
        ale = 1'h0;
        cs_n = 1'h1;
        w(4);
    endtask : ser
endmodule : mhcp_host

// *** tb/modem_host_control_port_tb_top.sv ***
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench of the host control port
module modem_host_control_port_tb_top;
    import mhcp_pkg::*;
    typedef struct packed {
        logic wm;
        logic [2:0] wa;
        logic [7:0] wd;
        logic rm;
        logic [2:0] ra;
        logic [7:0] ex;
    } mhcp_row_type;
    logic clk = 0, rst = 1, rxd = 0, dmd = 0, car = 0, ans = 0, llp = 0;
    logic [7:0] bus_out, oe_n, bus, ad, lc, ic, tc, q;
    logic ale, cs_n, rd_n, wr_n, sclk, int_oe_n, int_out, start, csel;
    logic cpd = 0;
    int fail_count = 0, checks_done = 0, starts = 0, drives = 0, n0;
    // Mode, address, data written; mode, address, value read back
    mhcp_row_type rows [9] = '{
        {1'h0, 3'h0, 8'h39, 1'h0, 3'h0, 8'h39},
        {1'h0, 3'h1, 8'hd3, 1'h1, 3'h1, 8'hd3},
        {1'h0, 3'h3, 8'h8a, 1'h0, 3'h3, 8'h8a},
        {1'h0, 3'h2, 8'hff, 1'h0, 3'h2, 8'h00},
        {1'h0, 3'h5, 8'h55, 1'h0, 3'h5, 8'h00},
        {1'h1, 3'h0, 8'h26, 1'h1, 3'h0, 8'h26},
        {1'h1, 3'h3, 8'h0c, 1'h0, 3'h3, 8'h0c},
        {1'h1, 3'h2, 8'hff, 1'h1, 3'h2, 8'h00},
        {1'h1, 3'h1, 8'h41, 1'h1, 3'h1, 8'h41}};

    always #12.5 clk = ~clk;
    assign bus = (~oe_n & bus_out) | (oe_n & ad);
    always @(posedge clk) begin
        starts <= starts + int'(start === 1'b1);
        drives <= drives + int'(oe_n !== 8'hff);
    end

    mhcp_host h (.clk(clk), .ad(ad), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .sclk(sclk), .bus(bus));
    mhcp_port #(.UNSCR_MARK_CYCLES(50)) u_dut (.CLK_SYS(clk), .RST(rst),
        .MUXED_ADDR_DATA_BUS_IN(bus), .MUXED_ADDR_DATA_BUS_OUT(bus_out),
        .MUXED_ADDR_DATA_BUS_OE_N(oe_n), .ADDR_LATCH_STROBE(ale),
        .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
        .EXT_SHIFT_CLOCK(sclk), .RECEIVE_DATA(rxd),
        .DEMOD_PRE_DESCRAMBLE(dmd), .CARRIER_DETECT(car),
        .ANSWER_TONE_DETECT(ans), .CALL_PROGRESS_DETECT(cpd),
        .LONG_LOOP_DETECT(llp), .INT_OUT(int_out), .INT_OE_N(int_oe_n),
        .LINE_CONTROL(lc), .INTERFACE_CONTROL(ic), .TONE_CONTROL(tc),
        .DUAL_TONE_DIAL_START(start), .CLKOUT_RATE_SEL(csel));

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    task automatic op(input logic s, input logic wr, input logic [2:0] a,
                      input logic [7:0] d);
        if (s) h.ser(wr, a, {1'h0, d}, 8, q);
        else h.par(wr, 1'h1, a, d, q);
    endtask : op

    initial begin
        wt(50000);
        fail_count++;
        complete_run();
    end

    initial begin
        wt(2);
        rst = 0;
        wt(6);
        foreach (rows[i]) begin
            op(rows[i].wm, 1'h1, rows[i].wa, rows[i].wd);
            op(rows[i].rm, 1'h0, rows[i].ra, 8'h00);
            chk(q, rows[i].ex);
        end
        op(0, 1, 3'h0, 8'h04);
        op(0, 1, 3'h1, 8'h08);
        chk({7'h00, csel}, 8'h01);
        n0 = drives;
        h.par(1, 0, 3'h0, 8'hff, q);
        h.par(0, 0, 3'h0, 8'h00, q);
        chk(8'(drives - n0), 8'h00);
        chk(lc, 8'h04);
        op(0, 1, 3'h0, 8'h30);
        chk({7'h00, csel}, 8'h00);
        op(0, 1, 3'h3, 8'h15);
        op(0, 1, 3'h0, 8'h32);
        chk(starts[7:0], 8'h01);
        op(0, 1, 3'h0, 8'h30);
        op(0, 1, 3'h3, 8'h05);
        op(0, 1, 3'h0, 8'h32);
        chk(starts[7:0], 8'h01);
        h.ser(1, 3'h3, 9'h10a, 9, q);
        chk(tc, 8'h0a);
        op(0, 1, 3'h1, 8'h20);
        llp = 1;
        wt(20);
        chk({7'h00, int_oe_n}, 8'h01);
        car = 1;
        wt(20);
        chk({6'h00, int_out, int_oe_n}, 8'h00);
        op(0, 0, 3'h2, 8'h00);
        chk(q, 8'h09);
        chk({7'h00, int_oe_n}, 8'h01);
        op(0, 1, 3'h1, 8'h00);
        ans = 1;
        wt(20);
        chk({7'h00, int_oe_n}, 8'h01);
        op(0, 1, 3'h1, 8'h20);
        chk({7'h00, int_oe_n}, 8'h01);
        cpd = 1;
        wt(20);
        chk({7'h00, int_oe_n}, 8'h00);
        op(0, 0, 3'h2, 8'h00);
        chk(q, 8'h0f);
        rxd = 1;
        dmd = 1;
        wt(30);
        chk({7'h00, int_oe_n}, 8'h01);
        wt(40);
        chk({7'h00, int_oe_n}, 8'h00);
        op(0, 0, 3'h2, 8'h00);
        chk(q, 8'h3f);
        op(0, 1, 3'h0, 8'h04);
        op(0, 1, 3'h1, 8'h08);
        op(0, 1, 3'h1, 8'h0c);
        chk(lc | ic | tc, 8'h00);
        chk({7'h00, csel}, 8'h00);
        op(0, 1, 3'h0, 8'h04);
        op(0, 1, 3'h1, 8'h08);
        op(0, 1, 3'h3, 8'h05);
        rst = 1;
        wt(2);
        chk(lc | ic | tc, 8'h00);
        chk({6'h00, csel, int_oe_n}, 8'h01);
        rst = 0;
        wt(6);
        op(0, 1, 3'h0, 8'h39);
        chk(lc, 8'h39);
        complete_run();
    end
endmodule : modem_host_control_port_tb_top

// *** verilog/mhcp_port.sv ***
`timescale 1ns/1ps
// How it works
// [R1] Four byte registers, address latched from bus
// [R2] Detect register read-only, others read/write
// [R3] Latch strobe falling edge captures address, select
// [R4] No select latched: bus undriven, no writes
// [R5] Parallel read drives bus while read low
// [R6] Parallel write lands on write strobe rising edge
// [R7] Host holds serial register select during operation
// [R8] Serial read shifts eight bits LSB first
// [R9] Data pin moves on shift clock falling edges
// [R10] Serial write loads register on write rising edge
// [R11] Latch high, select low selects serial mode
// [R12] Unscrambled mark after long steady high demod
// [R13] Condition change interrupts, except long loop and receive data
// [R14] Interrupt enable zero masks interrupt output
// [R15] Interrupt holds until detect read or reset
// [R16] Tone pair from code and tone mode
// [R17] Tone starts on transmit enable rise
// [R18] Clock output select, fast rate phase modes only
// [R19] Reset pin clears controls, crystal clock
// [R20] Host writes reserved bits as zero
// [R21] Tone register holds four-bit tone code
// [R22] Shifter ignores edges beyond eight per operation
module mhcp_port #(
    parameter int UNSCR_MARK_CYCLES = mhcp_pkg::UNSCR_MARK_CYCLES
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Multiplexed address/data bus
    input wire logic [mhcp_pkg::BUS_W-1:0] MUXED_ADDR_DATA_BUS_IN,
    output logic [mhcp_pkg::BUS_W-1:0] MUXED_ADDR_DATA_BUS_OUT,
    output logic [mhcp_pkg::BUS_W-1:0] MUXED_ADDR_DATA_BUS_OE_N,
    // Strobes and shift clock
    input wire logic ADDR_LATCH_STROBE,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic EXT_SHIFT_CLOCK,
    // Monitored conditions
    input wire logic RECEIVE_DATA,
    input wire logic DEMOD_PRE_DESCRAMBLE,
    input wire logic CARRIER_DETECT,
    input wire logic ANSWER_TONE_DETECT,
    input wire logic CALL_PROGRESS_DETECT,
    input wire logic LONG_LOOP_DETECT,
    // Open-drain interrupt
    output logic INT_OUT,
    output logic INT_OE_N,
    // Control to the modem core
    output logic [mhcp_pkg::BUS_W-1:0] LINE_CONTROL,
    output logic [mhcp_pkg::BUS_W-1:0] INTERFACE_CONTROL,
    output logic [mhcp_pkg::BUS_W-1:0] TONE_CONTROL,
    output logic DUAL_TONE_DIAL_START,
    output logic CLKOUT_RATE_SEL
);
    import mhcp_pkg::*;

    // =================================================================
    // Input synchronisation
    mhcp_sync_if pins ();

    assign pins.raw = {LONG_LOOP_DETECT, CALL_PROGRESS_DETECT,
                       ANSWER_TONE_DETECT, CARRIER_DETECT,
                       DEMOD_PRE_DESCRAMBLE, RECEIVE_DATA,
                       EXT_SHIFT_CLOCK, WRITE_STROBE_N, READ_STROBE_N,
                       CHIP_SELECT_N, ADDR_LATCH_STROBE,
                       MUXED_ADDR_DATA_BUS_IN};

    mhcp_sync u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .s(pins.sync)
    );

    logic [BUS_W-1:0] ad;
    logic latch_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic sclk_s;

    assign ad = pins.clean[SY_AD_LSB +: BUS_W];
    assign latch_s = pins.clean[SY_LATCH];
    assign cs_n_s = pins.clean[SY_CS_N];
    assign rd_n_s = pins.clean[SY_RD_N];
    assign wr_n_s = pins.clean[SY_WR_N];
    assign sclk_s = pins.clean[SY_SHIFT_CLK];

    // =================================================================
    // Edge detection on filtered strobes
    logic latch_d;
    logic rd_n_d;
    logic wr_n_d;
    logic sclk_d;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            latch_d <= 1'b0;
            rd_n_d <= 1'b1;
            wr_n_d <= 1'b1;
            sclk_d <= 1'b1;
        end else begin
            latch_d <= latch_s;
            rd_n_d <= rd_n_s;
            wr_n_d <= wr_n_s;
            sclk_d <= sclk_s;
        end
    end

    logic latch_fall;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic sclk_fall;
    logic serial_mode;

    assign latch_fall = latch_d && !latch_s;
    assign rd_fall = rd_n_d && !rd_n_s;
    assign rd_rise = !rd_n_d && rd_n_s;
    assign wr_rise = !wr_n_d && wr_n_s;
    assign sclk_fall = sclk_d && !sclk_s;
    assign serial_mode = latch_s && !cs_n_s; // see [R11]

    // =================================================================
    // Parallel address and select latch
    logic [ADDR_W-1:0] addr_lat;
    logic cs_lat;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            addr_lat <= '0;
            cs_lat <= 1'b0;
        end else if (latch_fall) begin
            addr_lat <= ad[ADDR_W-1:0]; // see [R1]
            cs_lat <= !cs_n_s; // see [R3]
        end
    end

    // Write data is sampled while the strobe is low, then held
    logic [BUS_W-1:0] wr_hold;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wr_hold <= REG_RESET;
        end else if (!wr_n_s) begin
            wr_hold <= ad;
        end
    end

    // =================================================================
    // Serial command shifter
    mhcp_ser_state_type ser_state;
    logic [3:0] ser_count;
    logic [BUS_W-1:0] ser_shift;
    logic [BUS_W-1:0] line_control_reg;
    logic [BUS_W-1:0] interface_control_reg;
    logic [BUS_W-1:0] tone_control_reg;
    logic [BUS_W-1:0] detect_status_reg;

    function automatic logic [BUS_W-1:0] reg_read(
        input logic [ADDR_W-1:0] a
    );
        case (a)
            ADDR_LINE_CTRL: reg_read = line_control_reg;
            ADDR_IFACE_CTRL: reg_read = interface_control_reg;
            ADDR_DETECT: reg_read = detect_status_reg;
            ADDR_TONE_CTRL: reg_read = tone_control_reg;
            default: reg_read = REG_RESET;
        endcase
    endfunction : reg_read

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ser_state <= SER_IDLE;
            ser_count <= '0;
            ser_shift <= REG_RESET;
        end else if (!serial_mode) begin
            ser_state <= SER_IDLE;
            ser_count <= '0;
        end else if (rd_fall) begin
            ser_state <= SER_OUT;
            ser_count <= '0;
            ser_shift <= reg_read(ad[ADDR_W-1:0]); // see [R8]
        end else if (rd_rise || wr_rise) begin
            ser_state <= SER_IDLE;
            ser_count <= '0; // see [R22]
        end else if (sclk_fall && ser_count < SER_BITS) begin // see [R22]
            ser_count <= ser_count + 4'h1;
            unique case (ser_state)
                SER_OUT: begin
                    ser_shift <= {1'b0, ser_shift[BUS_W-1:1]}; // see [R9]
                end
                SER_IDLE, SER_IN: begin
                    ser_state <= SER_IN;
                    ser_shift <= {ad[SER_DATA_BIT],
                                  ser_shift[BUS_W-1:1]}; // see [R10]
                end
            endcase
        end
    end

    // =================================================================
    // Register writes
    logic par_write;
    logic ser_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [BUS_W-1:0] wr_data;

    assign par_write = wr_rise && !serial_mode && cs_lat; // see [R4] [R6]
    assign ser_write = wr_rise && serial_mode; // see [R10]
    assign wr_addr = serial_mode ? ad[ADDR_W-1:0] : addr_lat;
    assign wr_data = serial_mode ? ser_shift : wr_hold;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            line_control_reg <= REG_RESET; // see [R19]
            interface_control_reg <= REG_RESET;
            tone_control_reg <= REG_RESET;
        end else if (par_write || ser_write) begin
            if (wr_addr == ADDR_IFACE_CTRL &&
                wr_data[IC_SOFT_RESET_BIT]) begin
                line_control_reg <= REG_RESET;
                interface_control_reg <= REG_RESET;
                tone_control_reg <= REG_RESET;
            end else begin
                case (wr_addr) // see [R2]
                    ADDR_LINE_CTRL: line_control_reg <= wr_data;
                    ADDR_IFACE_CTRL: interface_control_reg <= wr_data;
                    ADDR_TONE_CTRL: tone_control_reg <= wr_data; // see [R21]
                    default: ;
                endcase
            end
        end
    end

    // =================================================================
    // Bus drive
    logic par_drive;
    logic ser_drive;
    logic [BUS_W-1:0] ad_out;

    assign par_drive = !serial_mode && cs_lat && !rd_n_s; // see [R5]
    assign ser_drive = serial_mode && !rd_n_s; // see [R9]

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ad_out <= REG_RESET;
        end else if (serial_mode) begin
            ad_out <= REG_RESET;
            ad_out[SER_DATA_BIT] <= ser_shift[0]; // see [R8]
        end else begin
            ad_out <= reg_read(addr_lat);
        end
    end

    always_comb begin
        MUXED_ADDR_DATA_BUS_OE_N = OE_ALL_OFF; // see [R4]
        if (par_drive) begin
            MUXED_ADDR_DATA_BUS_OE_N = '0;
        end else if (ser_drive) begin
            MUXED_ADDR_DATA_BUS_OE_N[SER_DATA_BIT] = 1'b0;
        end
    end

    assign MUXED_ADDR_DATA_BUS_OUT = ad_out;

    // =================================================================
    // Monitored conditions
    logic [UNSCR_CNT_W-1:0] unscr_cnt;
    logic [UNSCR_CNT_W-1:0] unscr_target;
    logic unscr_flag;

    assign unscr_target = UNSCR_CNT_W'(UNSCR_MARK_CYCLES);
    assign unscr_flag = unscr_cnt == unscr_target;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            unscr_cnt <= '0;
        end else if (!pins.clean[SY_RAW_DEMOD]) begin
            unscr_cnt <= '0;
        end else if (!unscr_flag) begin
            unscr_cnt <= unscr_cnt + 1'b1; // see [R12]
        end
    end

    logic [BUS_W-1:0] next_detect;

    always_comb begin
        next_detect = REG_RESET;
        next_detect[DET_LONG_LOOP_BIT] = pins.clean[SY_LONG_LOOP];
        next_detect[DET_CALL_PROG_BIT] = pins.clean[SY_CALL_PROG];
        next_detect[DET_ANSWER_BIT] = pins.clean[SY_ANSWER];
        next_detect[DET_CARRIER_BIT] = pins.clean[SY_CARRIER];
        next_detect[DET_UNSCR_BIT] = unscr_flag; // see [R12]
        next_detect[DET_RX_DATA_BIT] = pins.clean[SY_RX_DATA];
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            detect_status_reg <= REG_RESET;
        end else begin
            detect_status_reg <= next_detect; // see [R2] [R13]
        end
    end

    // =================================================================
    // Interrupt
    logic int_en;
    logic int_set;
    logic detect_read;
    logic int_pend;

    assign int_en = interface_control_reg[IC_INT_ENABLE_BIT];
    assign int_set = int_en &&
        |((next_detect ^ detect_status_reg) & DET_INT_MASK); // see [R13]
    assign detect_read = rd_fall && (serial_mode ?
        ad[ADDR_W-1:0] == ADDR_DETECT :
        cs_lat && addr_lat == ADDR_DETECT);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            int_pend <= 1'b0;
        end else if (int_set) begin
            int_pend <= 1'b1;
        end else if (detect_read) begin
            int_pend <= 1'b0; // see [R15]
        end
    end

    assign INT_OUT = 1'b0;
    assign INT_OE_N = !(int_pend && int_en); // see [R14]

    // =================================================================
    // Tone start and clock select
    logic tx_en_d;
    logic tone_start;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            tx_en_d <= 1'b0;
            tone_start <= 1'b0;
        end else begin
            tx_en_d <= line_control_reg[LC_TX_ENABLE_BIT];
            tone_start <= line_control_reg[LC_TX_ENABLE_BIT] && !tx_en_d &&
                tone_control_reg[TONE_MODE_BIT]; // see [R16] [R17]
        end
    end

    logic [3:0] tx_mode;
    logic psk_mode;

    assign tx_mode = line_control_reg[LC_MODE_MSB:LC_MODE_LSB];
    assign psk_mode = tx_mode >= MODE_PSK_FIRST && tx_mode <= MODE_PSK_LAST;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CLKOUT_RATE_SEL <= 1'b0; // see [R19]
        end else begin
            CLKOUT_RATE_SEL <= psk_mode &&
                interface_control_reg[IC_CLK_CTRL_BIT]; // see [R18]
        end
    end

    assign LINE_CONTROL = line_control_reg;
    assign INTERFACE_CONTROL = interface_control_reg;
    assign TONE_CONTROL = tone_control_reg;
    assign DUAL_TONE_DIAL_START = tone_start;

    // =================================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    sequence s_par_line_write;
        par_write && addr_lat == ADDR_LINE_CTRL;
    endsequence

    sequence s_ser_read_start;
        serial_mode && rd_fall ##1 serial_mode && !rd_n_s;
    endsequence

    a_bus_no_select: assert property ( // see [R4]
        !serial_mode && !cs_lat |-> MUXED_ADDR_DATA_BUS_OE_N == OE_ALL_OFF)
        else $error("bus driven without latched select");

    a_bus_read_drive: assert property ( // see [R5]
        MUXED_ADDR_DATA_BUS_OE_N != OE_ALL_OFF |-> !rd_n_s &&
        (serial_mode || cs_lat))
        else $error("bus driven outside a read");

    a_par_write_data: assert property ( // see [R6]
        s_par_line_write |=> line_control_reg == $past(wr_hold))
        else $error("parallel write data not stored");

    a_ser_read_lsb: assert property ( // see [R8]
        s_ser_read_start |=>
        MUXED_ADDR_DATA_BUS_OUT[SER_DATA_BIT] == $past(ser_shift[0], 1))
        else $error("serial read first bit wrong");

    a_ser_ignore_extra: assert property ( // see [R22]
        ser_count == SER_BITS && sclk_fall && !rd_fall && !rd_rise &&
        !wr_rise |=> $stable(ser_shift))
        else $error("shifter moved after eight edges");

    a_unscr_mark_time: assert property ( // see [R12]
        detect_status_reg[DET_UNSCR_BIT] |->
        $past(unscr_cnt) == unscr_target)
        else $error("unscrambled mark flagged early");

    a_int_on_change: assert property ( // see [R13]
        int_en && next_detect[DET_CARRIER_BIT] !=
        detect_status_reg[DET_CARRIER_BIT] |=> int_pend)
        else $error("condition change raised no interrupt");

    a_int_long_loop: assert property ( // see [R13]
        !int_pend && (next_detect ^ detect_status_reg) ==
        (8'h01 << DET_LONG_LOOP_BIT) |=> !int_pend)
        else $error("long loop change raised an interrupt");

    a_int_masked: assert property ( // see [R14]
        !int_en |-> INT_OE_N)
        else $error("interrupt driven while masked");

    a_int_holds: assert property ( // see [R15]
        !INT_OE_N && !detect_read && int_en |=> !INT_OE_N || !int_en)
        else $error("interrupt dropped before detect read");

    a_tone_start: assert property ( // see [R17]
        tone_start |-> $past(tone_control_reg[TONE_MODE_BIT]) &&
        $past(line_control_reg[LC_TX_ENABLE_BIT]) && !$past(tx_en_d))
        else $error("tone start without enable rise");

    a_clk_select: assert property ( // see [R18]
        CLKOUT_RATE_SEL |-> $past(psk_mode))
        else $error("fast clock outside phase-shift mode");
endmodule : mhcp_port

// *** verilog/mhcp_sync.sv ***
`timescale 1ns/1ps
// =====================================================================
// Three-stage synchroniser; a level is accepted once stages two and
// three agree
module mhcp_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin levels
    mhcp_sync_if.sync s
);
    import mhcp_pkg::*;

    logic [SYNC_W-1:0] ff1;
    logic [SYNC_W-1:0] ff2;
    logic [SYNC_W-1:0] ff3;
    logic [SYNC_W-1:0] level;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ff1 <= SYNC_IDLE;
            ff2 <= SYNC_IDLE;
            ff3 <= SYNC_IDLE;
        end else begin
            ff1 <= s.raw;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= SYNC_IDLE;
        end else begin
            for (int i = 0; i < SYNC_W; i++) begin
                if (ff2[i] == ff3[i]) begin
                    level[i] <= ff3[i];
                end
            end
        end
    end

    assign s.clean = level;
endmodule : mhcp_sync
